// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        mclk, reset_n, wr, rd, cs_n, up_dn, vpp_en, pot_por_n;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, v;
	logic [4:0]  tap;
	int          n_errors, n_compared;
	// short programming waits so a whole sequence fits the run
	udwc_ctrl #(.VPP_CYC(32'h14), .PHIGH_CYC(32'h0C), .PLOW_CYC(32'h0C),
		.VOFF_CYC(32'h0C)) i_dut (.mclk(mclk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cs_n(cs_n), .up_dn(up_dn), .vpp_en(vpp_en));
	udwc_pot_model i_pot (.por_n(pot_por_n), .cs_n(cs_n), .up_dn(up_dn),
		.vpp_en(vpp_en), .tap(tap));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		v = rdata;
	endtask
	task automatic adjust(input logic [4:0] n, input logic up, input logic [4:0] e);
		wreg(4'h1, {27'h0, n});
		wreg(4'h0, {30'h0, up, 1'b1});
		v = 32'h1;
		// polling bounded so a stuck busy ends here, not in the watchdog
		for (int i = 0; i < 400 && v[0] !== 1'b0; i++)
			rreg(4'h2);
		chk("done", v[1:0], 2'h2);
		rreg(4'h3);
		chk("tracked tap", v[4:0], e);
		chk("pot tap", tap, e);
		wreg(4'h2, 32'h2);
		$display("test adjust done");
	endtask
	task automatic prog_run(input logic [31:0] c, input logic [7:0] e);
		wreg(4'h0, c);
		v = 32'h1;
		for (int i = 0; i < 400 && v[0] !== 1'b0; i++)
			rreg(4'h2);
		chk("program status", v[7:0], e);
		wreg(4'h2, 32'h2);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		// all scenarios take under two thousand cycles; wide margin
		repeat (20000) @(posedge mclk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		reset_n = 1'b0;
		pot_por_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		pot_por_n <= 1'b1;
		rreg(4'h3);
		chk("tap reset", v[4:0], 5'h10);
		chk("pot power-up", tap, 5'h10);
		rreg(4'h2);
		chk("status reset", v, 32'h0);
		rreg(4'hA);
		chk("unmapped", v, 32'h0);
		$display("test reset done");
		adjust(5'h03, 1'b1, 5'h13);
		adjust(5'h14, 1'b0, 5'h00);
		adjust(5'h1F, 1'b1, 5'h1F);
		adjust(5'h0F, 1'b0, 5'h10);
		adjust(5'h00, 1'b0, 5'h10);
		wreg(4'h0, 32'h5);
		repeat (20) @(posedge mclk);
		chk("supply on", vpp_en, 1'b1);
		chk("select idle", cs_n, 1'b1);
		reset_n <= 1'b0;
		pot_por_n <= 1'b0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		pot_por_n <= 1'b1;
		@(negedge mclk);
		chk("pot reload", tap, 5'h10);
		chk("supply off", vpp_en, 1'b0);
		$display("test program abort done");
		adjust(5'h04, 1'b1, 5'h14);
		prog_run(32'h5, 8'hAA);
		chk("supply dropped", vpp_en, 1'b0);
		chk("pot programmed", tap, 5'h14);
		adjust(5'h02, 1'b0, 5'h12);
		pot_por_n <= 1'b0;
		@(posedge mclk);
		pot_por_n <= 1'b1;
		@(negedge mclk);
		chk("pot reload programmed", tap, 5'h14);
		wreg(4'h3, 32'h10);
		rreg(4'h3);
		chk("tap resync", v[12:0], 13'h1414);
		adjust(5'h01, 1'b1, 5'h15);
		wreg(4'h0, 32'hD);
		repeat (10) @(posedge mclk);
		chk("relock refused", vpp_en, 1'b0);
		adjust(5'h01, 1'b0, 5'h14);
		prog_run(32'hD, 8'hDA);
		chk("pot locked", tap, 5'h14);
		wreg(4'h1, 32'h3);
		wreg(4'h0, 32'h3);
		repeat (10) @(posedge mclk);
		chk("locked select", cs_n, 1'b1);
		rreg(4'h2);
		chk("locked status", v[7:0], 8'hD8);
		rreg(4'h3);
		chk("locked tap", v[12:0], 13'h1414);
		$display("test program and lock done");
		tally_and_finish();
	end
endmodule
bind udwc_ctrl udwc_checker i_chk (.mclk(mclk), .reset_n(reset_n), .rd(rd),
	.rdata(rdata), .cs_n(cs_n), .up_dn(up_dn), .vpp_en(vpp_en));
`default_nettype wire

// *** bench/udwc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module udwc_checker (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        cs_n,
	input wire logic        up_dn,
	input wire logic        vpp_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	read_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("stray read data");
	step_low_a: assert property (!cs_n && $fell(up_dn) |-> !up_dn[*3])
		else $error("short low step");
	step_high_a: assert property (!cs_n && $rose(up_dn) |-> up_dn[*3])
		else $error("short high step");
	dir_setup_a: assert property ($fell(cs_n) |-> $stable(up_dn))
		else $error("direction moved at select");
	end_high_a: assert property ($rose(cs_n) |-> up_dn && $past(up_dn))
		else $error("session ended low");
	supply_order_a: assert property ($rose(vpp_en) |-> up_dn && cs_n)
		else $error("supply before setup");
	supply_wait_a: assert property ($rose(vpp_en) |-> cs_n[*8])
		else $error("select too soon");
	pulse_high_a: assert property (vpp_en && $rose(cs_n) |-> cs_n[*8])
		else $error("short pulse");
endmodule
`default_nettype wire

// *** bench/udwc_pot_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module udwc_pot_model (
	input wire logic       por_n,
	input wire logic       cs_n,
	input wire logic       up_dn,
	input wire logic       vpp_en,
	output logic     [4:0] tap
);
	logic       inc, arm, prog, lock;
	logic [4:0] store;
	int         pulses;
	// fuses blank before the first power-up
	initial begin
		prog = 1'b0;
		lock = 1'b0;
		arm = 1'b0;
		tap = 5'h10;
	end
	task automatic step();
		if (lock || arm || !por_n)
			return;
		if (inc && tap != 5'h1F)
			tap = tap + 5'h01;
		else if (!inc && tap != 5'h00)
			tap = tap - 5'h01;
	endtask
	always @(posedge por_n) begin
		tap = prog ? store : 5'h10;
		arm = 1'b0;
	end
	always @(negedge cs_n) begin
		// pulse falls inside a programming sequence keep the count
		if (!arm) begin
			inc = up_dn;
			arm = vpp_en && up_dn && !lock;
			pulses = 0;
		end
	end
	always @(posedge up_dn)
		if (!cs_n)
			step();
	always @(posedge cs_n) begin
		if (arm)
			pulses++;
		else if (!up_dn)
			step();
	end
	always @(negedge vpp_en) begin
		if (arm && pulses >= 5) begin
			prog = 1'b1;
			store = tap;
			lock = pulses >= 6;
		end
		arm = 1'b0;
	end
endmodule
`default_nettype wire

// *** hw/udwc_ctrl.v ***
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "udwc_regs.vh"
module udwc_ctrl #(
	parameter        TW        = 18,
	parameter [31:0] VPP_CYC   = `UDWC_VPP_CS_CYC,
	parameter [31:0] PHIGH_CYC = `UDWC_PHIGH_CYC,
	parameter [31:0] PLOW_CYC  = `UDWC_PLOW_CYC,
	parameter [31:0] VOFF_CYC  = `UDWC_VOFF_CS_CYC
) (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	output reg         cs_n,
	output reg         up_dn,
	output reg         vpp_en
);
	localparam [7:0] S_IDLE = 8'h01, S_SETUP = 8'h02, S_HIGH = 8'h04;
	localparam [7:0] S_LOW = 8'h08, S_END = 8'h10, S_VPP = 8'h20;
	localparam [7:0] S_PHIGH = 8'h40, S_PLOW = 8'h80;

	reg [7:0]    st_q;
	reg [4:0]    steps_q;
	reg          dir_up_q;
	reg          lock_q;
	reg [2:0]    pulses_q;
	reg          done_q;
	reg          locked_q;
	reg [4:0]    tap_q;
	reg [4:0]    progtap_q;
	reg          progd_q;
	reg          tload;
	reg [TW-1:0] tval;
	wire         texp;

	udwc_timer #(.WIDTH(TW)) u_tmr (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (tload),
		.value   (tval),
		.expired (texp)
	);

	wire busy = (st_q != S_IDLE);
	wire go   = wr && addr == `UDWC_REG_CTRL && wdata[`UDWC_CTRL_GO_BIT];
	wire prog = go && wdata[`UDWC_CTRL_PROG_BIT];
	wire no_steps = (steps_q == 5'h00);
	// relock only from the most recently programmed tap
	wire refuse = prog && wdata[`UDWC_CTRL_LOCK_BIT] && progd_q &&
	              (tap_q != progtap_q);

	// timer loads, cut to the timer width on purpose
	localparam [31:0] STEP_HI_CYC = `UDWC_STEP_HIGH_CYC;
	localparam [31:0] STEP_LO_CYC = `UDWC_STEP_LOW_CYC;
	wire [TW-1:0] t_step_hi = STEP_HI_CYC[TW-1:0];
	wire [TW-1:0] t_step_lo = STEP_LO_CYC[TW-1:0];
	wire [TW-1:0] t_vpp     = VPP_CYC[TW-1:0];
	wire [TW-1:0] t_phigh   = PHIGH_CYC[TW-1:0];
	wire [TW-1:0] t_plow    = PLOW_CYC[TW-1:0];
	wire [TW-1:0] t_voff    = VOFF_CYC[TW-1:0];

	// tracked copy of the device's counter, saturating like the part
	function [4:0] step_tap;
		input [4:0] t;
		input       up;
		begin
			if (up)
				step_tap = (t == `UDWC_TAP_MAX) ? t : t + 5'h01;
			else
				step_tap = (t == 5'h00) ? t : t - 5'h01;
		end
	endfunction

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q      <= S_IDLE;
			cs_n      <= 1'b1;
			up_dn     <= 1'b1;
			vpp_en    <= 1'b0;
			steps_q   <= 5'h00;
			dir_up_q  <= 1'b1;
			lock_q    <= 1'b0;
			pulses_q  <= 3'h0;
			done_q    <= 1'b0;
			locked_q  <= 1'b0;
			tap_q     <= `UDWC_TAP_DEFAULT;
			progtap_q <= `UDWC_TAP_DEFAULT;
			progd_q   <= 1'b0;
			tload     <= 1'b0;
			tval      <= {TW{1'b0}};
			rdata     <= 32'h0000_0000;
		end else begin
			tload <= 1'b0;
			rdata <= 32'h0000_0000;
			if (rd) begin
				case (addr)
				`UDWC_REG_STEPS:  rdata <= {27'h0, steps_q};
				`UDWC_REG_STATUS: rdata <= {24'h0, pulses_q, locked_q,
					progd_q, 1'b0, done_q, busy};
				`UDWC_REG_TAP:    rdata <= {19'h0, progtap_q, 3'h0, tap_q};
				default:          rdata <= 32'h0000_0000;
				endcase
			end
			if (wr && addr == `UDWC_REG_STEPS && !busy)
				steps_q <= wdata[4:0];
			if (wr && addr == `UDWC_REG_TAP && !busy &&
			    wdata[`UDWC_CTRL_ZERO_BIT]) begin
				// resync after device power cycle
				tap_q <= progd_q ? progtap_q : `UDWC_TAP_DEFAULT;
			end
			if (wr && addr == `UDWC_REG_STATUS && wdata[`UDWC_STAT_DONE_BIT])
				done_q <= 1'b0;
			case (st_q)
			S_IDLE: begin
				// locked parts never see another session
				if (go && !locked_q && !prog && no_steps) begin
					// a zero-step decrement would still step once at
					// the select rise, so no session is run
					done_q <= 1'b1;
				end else if (go && !locked_q && !refuse) begin
					up_dn  <= prog ? 1'b1 : wdata[`UDWC_CTRL_UP_BIT];
					dir_up_q <= wdata[`UDWC_CTRL_UP_BIT];
					lock_q <= wdata[`UDWC_CTRL_LOCK_BIT];
					pulses_q <= 3'h0;
					tload  <= 1'b1;
					tval   <= t_step_lo;
					st_q   <= prog ? S_VPP : S_SETUP;
				end
			end
			S_SETUP: if (texp && !tload) begin
				// up_dn holds the direction across the select fall
				cs_n  <= 1'b0;
				tload <= 1'b1;
				tval  <= t_step_hi;
				st_q  <= S_HIGH;
			end
			S_HIGH: if (texp && !tload) begin
				tload <= 1'b1;
				if (steps_q == 5'h00) begin
					// up_dn is high here, so the select rise adds no step
					tval <= t_step_hi;
					st_q <= S_END;
				end else begin
					up_dn <= 1'b0;
					tval  <= t_step_lo;
					st_q  <= S_LOW;
				end
			end
			S_LOW: if (texp && !tload) begin
				up_dn   <= 1'b1;
				tap_q   <= step_tap(tap_q, dir_up_q);
				steps_q <= steps_q - 5'h01;
				tload   <= 1'b1;
				tval    <= t_step_hi;
				st_q    <= S_HIGH;
			end
			S_END: if (texp && !tload) begin
				cs_n   <= 1'b1;
				up_dn  <= 1'b1;
				done_q <= 1'b1;
				st_q   <= S_IDLE;
			end
			S_VPP: if (texp && !tload) begin
				if (!vpp_en) begin
					vpp_en <= 1'b1;
					tload  <= 1'b1;
					tval   <= t_vpp;
				end else begin
					cs_n  <= 1'b0;
					tload <= 1'b1;
					tval  <= t_plow;
					st_q  <= S_PLOW;
				end
			end
			S_PLOW: if (texp && !tload) begin
				if (pulses_q == (lock_q ? `UDWC_PULSES_LOCK
				                        : `UDWC_PULSES_PROG)) begin
					vpp_en    <= 1'b0;
					progd_q   <= 1'b1;
					progtap_q <= tap_q;  // relock stores current tap
					locked_q  <= lock_q;
					tload     <= 1'b1;
					tval      <= t_voff;
					st_q      <= S_END;
				end else begin
					cs_n     <= 1'b1;
					pulses_q <= pulses_q + 3'h1;
					tload    <= 1'b1;
					tval     <= t_phigh;
					st_q     <= S_PHIGH;
				end
			end
			S_PHIGH: if (texp && !tload) begin
				cs_n  <= 1'b0;
				tload <= 1'b1;
				tval  <= t_plow;
				st_q  <= S_PLOW;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** hw/udwc_regs.vh ***
`ifndef UDWC_REGS_VH
`define UDWC_REGS_VH

// software register offsets (word index on the command port)
`define UDWC_REG_CTRL        4'h0
`define UDWC_REG_STEPS       4'h1
`define UDWC_REG_STATUS      4'h2
`define UDWC_REG_TAP         4'h3

// control register fields (ZERO is read on tap register writes)
`define UDWC_CTRL_GO_BIT     0
`define UDWC_CTRL_UP_BIT     1
`define UDWC_CTRL_PROG_BIT   2
`define UDWC_CTRL_LOCK_BIT   3
`define UDWC_CTRL_ZERO_BIT   4

// status register fields
`define UDWC_STAT_BUSY_BIT   0
`define UDWC_STAT_DONE_BIT   1

// device figures
`define UDWC_TAPS            32
`define UDWC_TAP_MAX         5'h1F
`define UDWC_TAP_DEFAULT     5'h10
`define UDWC_PULSES_PROG     3'h5
`define UDWC_PULSES_LOCK     3'h6

// timing, figures as printed
`define UDWC_CLK_NS          40
`define UDWC_STEP_HIGH_NS    100
`define UDWC_STEP_LOW_NS     100
`define UDWC_VPP_TO_CS_MS    1
`define UDWC_CS_TO_VPP_MS    5
`define UDWC_PULSE_HIGH_MS   5
`define UDWC_PULSE_LOW_MS    5
`define UDWC_VPP_OFF_TO_CS_MS 1

// cycle counts, least times rounded up
`define UDWC_CYC_NS(ns)  (((ns) + `UDWC_CLK_NS - 1) / `UDWC_CLK_NS)
`define UDWC_CYC_MS(ms)  (((ms) * 1000000 + `UDWC_CLK_NS - 1) / `UDWC_CLK_NS)
`define UDWC_STEP_HIGH_CYC  `UDWC_CYC_NS(`UDWC_STEP_HIGH_NS)
`define UDWC_STEP_LOW_CYC   `UDWC_CYC_NS(`UDWC_STEP_LOW_NS)
`define UDWC_VPP_CS_CYC     `UDWC_CYC_MS(`UDWC_VPP_TO_CS_MS)
`define UDWC_CS_VPP_CYC     `UDWC_CYC_MS(`UDWC_CS_TO_VPP_MS)
`define UDWC_PHIGH_CYC      `UDWC_CYC_MS(`UDWC_PULSE_HIGH_MS)
`define UDWC_PLOW_CYC       `UDWC_CYC_MS(`UDWC_PULSE_LOW_MS)
`define UDWC_VOFF_CS_CYC    `UDWC_CYC_MS(`UDWC_VPP_OFF_TO_CS_MS)

`endif

// *** hw/udwc_timer.v ***
`timescale 1ns/1ps
`default_nettype none
// loadable down-counter; expired is high when the count reached zero
module udwc_timer #(
	parameter WIDTH = 18
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             load,
	input  wire [WIDTH-1:0] value,
	output wire             expired
);
	reg [WIDTH-1:0] cnt_q;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			cnt_q <= {WIDTH{1'b0}};
		else if (load)
			cnt_q <= value;
		else if (cnt_q != {WIDTH{1'b0}})
			cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
	end

	assign expired = (cnt_q == {WIDTH{1'b0}});
endmodule
`default_nettype wire
